//--- rtl/sst_pkg.sv
package sst_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [3:0] SST_IDX_TX_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] SST_IDX_RX_STATUS_CONTROL = 4'h1;
	localparam logic [3:0] SST_IDX_TX_HOLDING = 4'h2;
	localparam logic [3:0] SST_IDX_INTERRUPT_CONTROL = 4'h3;
	localparam logic [3:0] SST_IDX_IRQ_STATUS = 4'h4;
	localparam logic [3:0] SST_IDX_IRQ_MASK = 4'h5;
	localparam logic [3:0] SST_IDX_CORE_CONTROL = 4'h6;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	// tx_status_control
	localparam int SST_TXS_CLOCK_SOURCE = 7;
	localparam int SST_TXS_NINE_BIT = 6;
	localparam int SST_TXS_TX_ENABLE = 5;
	localparam int SST_TXS_SYNC_MODE = 4;
	localparam int SST_TXS_SHIFT_EMPTY = 1;
	localparam int SST_TXS_NINTH_BIT = 0;
	// rx_status_control
	localparam int SST_RXS_PORT_ON = 7;
	localparam int SST_RXS_SINGLE_RX = 5;
	localparam int SST_RXS_CONT_RX = 4;
	localparam int SST_RXS_ADDR_DETECT = 3;
	// interrupt_control
	localparam int SST_INT_GLOBAL = 7;
	localparam int SST_INT_PERIPH = 6;
	localparam int SST_INT_TX_ENABLE = 4;
	// irq status / mask
	localparam int SST_IRQ_TX_FLAG = 0;
	localparam int SST_IRQ_CHAR_DONE = 1;
	// core control
	localparam int SST_CORE_HALT = 0;
	localparam int SST_CORE_WAKE = 1;
	localparam int SST_CORE_VECTOR = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SST_RST_TX_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] SST_RST_RX_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] SST_RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [8:0] SST_RST_DATA = 9'h000;
	localparam logic [1:0] SST_RST_IRQ = 2'h0;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sst_bus_req_type;

	typedef struct packed {
		logic clk_in;
		logic clk_out;
		logic clk_oe;
		logic data_out;
		logic data_oe;
	} sst_pins_type;

	typedef enum logic [1:0] {
		SST_IDLE,
		SST_SHIFT
	} sst_state_type;

endpackage : sst_pkg

//--- rtl/sst_tx.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// Summary of operation
// - slave transmit behaves as master transmit except clock source and halt
// - on halt with two queued, first moves to shift register and shifts
// - second character stays in holding register while first shifts
// - transmit flag stays clear while second character waits
// - after first leaves, second moves to shifter, then flag sets
// - flag with periph and tx enables wakes core, continues next instr
// - with global enable also set, core vectors to service routine
// - writing low eight bits to holding register starts transmission
// - slave takes shift clock on clock pin, its driver disabled
// - data bit changes on leading edge, stable at trailing edge
// - exactly one data bit moves per shift clock cycle
module sst_tx
	import sst_pkg::*;
#(
	parameter int DATA_BITS = 8 // low character width
) (
	input wire logic clk, // core clock, 250 MHz
	input wire logic sys_rst, // async reset, active high
	input wire logic [3:0] reg_addr, // register index
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic shift_clock_pin_in, // shift clock pin level
	output logic shift_clock_pin_out, // shift clock pin drive value
	output logic shift_clock_pin_oe, // shift clock pin drive enable
	output logic data_pin_out, // serial data out
	output logic data_pin_oe, // serial data drive enable
	input wire logic core_halt, // core is in low-power halt
	output logic core_wake, // wake request to core
	output logic core_vector, // take interrupt vector on wake
	output logic irq // level interrupt
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0] tx_status_control_reg;
	logic [7:0] rx_status_control_reg;
	logic [7:0] interrupt_control_reg;
	logic [DATA_BITS:0] tx_holding_reg;
	logic holding_full_reg;
	logic [DATA_BITS:0] tx_shift_reg;
	logic [3:0] bit_count_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic tx_flag;
	logic [31:0] rdata_reg;
	sst_state_type state_reg;
	sst_pins_type pins;

	logic slave_tx_mode;
	logic [3:0] char_len;
	logic load_shift;
	logic char_done;
	logic wr_holding;
	logic clk_meta_reg;
	logic clk_sync_reg;
	logic clk_prev_reg;
	logic lead_edge;
	logic trail_edge;
	logic halt_meta_reg;
	logic halt_sync_reg;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	// slave transmit: sync, port on, clock from pin, receivers off
	assign slave_tx_mode = tx_status_control_reg[SST_TXS_SYNC_MODE]
		& rx_status_control_reg[SST_RXS_PORT_ON]
		& ~tx_status_control_reg[SST_TXS_CLOCK_SOURCE]
		& ~rx_status_control_reg[SST_RXS_SINGLE_RX]
		& ~rx_status_control_reg[SST_RXS_CONT_RX]
		& ~rx_status_control_reg[SST_RXS_ADDR_DETECT];
	assign char_len = tx_status_control_reg[SST_TXS_NINE_BIT]
		? 4'(DATA_BITS + 1) : 4'(DATA_BITS);
	assign wr_holding = reg_wr && reg_addr == SST_IDX_TX_HOLDING;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// two flops on the external clock and the halt level
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_meta_reg <= 1'b0;
			clk_sync_reg <= 1'b0;
			clk_prev_reg <= 1'b0;
			halt_meta_reg <= 1'b0;
			halt_sync_reg <= 1'b0;
		end else begin
			clk_meta_reg <= shift_clock_pin_in;
			clk_sync_reg <= clk_meta_reg;
			clk_prev_reg <= clk_sync_reg;
			halt_meta_reg <= core_halt;
			halt_sync_reg <= halt_meta_reg;
		end
	end

	// idle-low clock: rising is leading, falling is trailing
	// edges are seen two to three core clocks late, so each
	// half period of the shift clock must span several core
	// clocks; a faster master would have edges merged or lost.
	// the previous-level flop resets low to match the idle pin,
	// so no false leading edge follows reset.
	assign lead_edge = clk_sync_reg & ~clk_prev_reg;
	assign trail_edge = ~clk_sync_reg & clk_prev_reg;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// software-written control bits; shift-empty bit is live status
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_status_control_reg <= SST_RST_TX_STATUS_CONTROL;
			rx_status_control_reg <= SST_RST_RX_STATUS_CONTROL;
			interrupt_control_reg <= SST_RST_INTERRUPT_CONTROL;
			irq_mask_reg <= SST_RST_IRQ;
		end else if (reg_wr) begin
			case (reg_addr)
			SST_IDX_TX_STATUS_CONTROL: begin
				tx_status_control_reg <= reg_wdata[7:0];
			end
			SST_IDX_RX_STATUS_CONTROL: begin
				rx_status_control_reg <= reg_wdata[7:0];
			end
			SST_IDX_INTERRUPT_CONTROL: begin
				interrupt_control_reg <= reg_wdata[7:0];
			end
			SST_IDX_IRQ_MASK: begin
				irq_mask_reg <= reg_wdata[1:0];
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// holding register
	// ----------------------------------------------------------------
	// write of the low bits loads the ninth bit beside it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_holding_reg <= SST_RST_DATA;
			holding_full_reg <= 1'b0;
		end else if (wr_holding
			&& tx_status_control_reg[SST_TXS_TX_ENABLE]) begin
			tx_holding_reg <= {tx_status_control_reg[SST_TXS_NINTH_BIT],
				reg_wdata[DATA_BITS-1:0]};
			holding_full_reg <= 1'b1;
		end else if (load_shift) begin
			holding_full_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// shifter
	// ----------------------------------------------------------------
	// load only when idle; halt does not stop the shifter
	assign load_shift = state_reg == SST_IDLE && holding_full_reg
		&& slave_tx_mode
		&& tx_status_control_reg[SST_TXS_TX_ENABLE];
	assign char_done = state_reg == SST_SHIFT && trail_edge
		&& bit_count_reg == char_len - 4'h1;

	// lsb first; next bit presented on each leading edge after the first
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= SST_IDLE;
			tx_shift_reg <= SST_RST_DATA;
			bit_count_reg <= 4'h0;
		end else begin
			case (state_reg)
			SST_IDLE: begin
				if (load_shift) begin
					tx_shift_reg <= tx_holding_reg;
					bit_count_reg <= 4'h0;
					state_reg <= SST_SHIFT;
				end
			end
			SST_SHIFT: begin
				if (!slave_tx_mode) begin
					state_reg <= SST_IDLE;
				end else if (char_done) begin
					state_reg <= SST_IDLE;
				end else if (trail_edge) begin
					bit_count_reg <= bit_count_reg + 4'h1;
				end else if (lead_edge && bit_count_reg != 4'h0) begin
					tx_shift_reg <= {1'b0, tx_shift_reg[DATA_BITS:1]};
				end
			end
			default: begin
				state_reg <= SST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flag, interrupt status and wake
	// ----------------------------------------------------------------
	// flag is the holding register's emptiness while enabled
	// the same expression serves in and out of halt: the shifter
	// keeps running in halt, so a second character stays queued
	// and holds the flag low until the first has left.
	assign tx_flag = ~holding_full_reg
		& tx_status_control_reg[SST_TXS_TX_ENABLE];

	// sticky status; set wins over write-one clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status_reg <= SST_RST_IRQ;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == SST_IRQ_TX_FLAG && load_shift)
					|| (i == SST_IRQ_CHAR_DONE && char_done)) begin
					irq_status_reg[i] <= 1'b1;
				end else if (reg_wr && reg_addr == SST_IDX_IRQ_STATUS
					&& reg_wdata[i]) begin
					irq_status_reg[i] <= 1'b0;
				end
			end
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// wake on raised flag during halt, vector if global on
	assign core_wake = halt_sync_reg & tx_flag
		& interrupt_control_reg[SST_INT_PERIPH]
		& interrupt_control_reg[SST_INT_TX_ENABLE];
	assign core_vector = core_wake
		& interrupt_control_reg[SST_INT_GLOBAL];

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	always_comb begin
		pins.clk_in = clk_sync_reg;
		pins.clk_out = 1'b0;
		pins.clk_oe = 1'b0;
		pins.data_out = tx_shift_reg[0];
		pins.data_oe = slave_tx_mode;
	end
	assign shift_clock_pin_out = pins.clk_out;
	assign shift_clock_pin_oe = pins.clk_oe;
	assign data_pin_out = pins.data_out;
	assign data_pin_oe = pins.data_oe;

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
			SST_IDX_TX_STATUS_CONTROL: begin
				rdata_reg <= {24'h0, tx_status_control_reg[7:2],
					state_reg == SST_IDLE, tx_status_control_reg[0]};
			end
			SST_IDX_RX_STATUS_CONTROL: begin
				rdata_reg <= {24'h0, rx_status_control_reg};
			end
			SST_IDX_TX_HOLDING: begin
				rdata_reg <= {23'h0, tx_holding_reg};
			end
			SST_IDX_INTERRUPT_CONTROL: begin
				rdata_reg <= {24'h0, interrupt_control_reg};
			end
			SST_IDX_IRQ_STATUS: begin
				rdata_reg <= {30'h0, irq_status_reg};
			end
			SST_IDX_IRQ_MASK: begin
				rdata_reg <= {30'h0, irq_mask_reg};
			end
			SST_IDX_CORE_CONTROL: begin
				rdata_reg <= {29'h0, core_vector, core_wake, tx_flag};
			end
			default: begin
				rdata_reg <= 32'h0;
			end
			endcase
		end
	end
	assign reg_rdata = rdata_reg;

endmodule // sst_tx

//--- dv/sst_tx_props.sv
`timescale 1ns/1ns
// ----
// port checks
// ----
module sst_tx_props
	import sst_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic sys_rst, // async reset
	input wire logic [3:0] reg_addr, // register index
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic shift_clock_pin_in, // shift clock level
	input wire logic shift_clock_pin_out, // clock drive value
	input wire logic shift_clock_pin_oe, // clock drive enable
	input wire logic data_pin_out, // serial data
	input wire logic core_halt, // core halt
	input wire logic core_wake, // wake request
	input wire logic core_vector // vector request
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_clk_drv_off: assert property (!shift_clock_pin_oe && !shift_clock_pin_out)
		else $error("clock pin driven");
	a_vector_wake: assert property (core_vector |-> core_wake)
		else $error("vector without wake");
	a_wake_halt: assert property (!core_halt [*4] |-> !core_wake)
		else $error("wake outside halt");
	a_bit_stable: assert property (shift_clock_pin_in [*6] |-> $stable(data_pin_out))
		else $error("data moved while clock high");
	a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_wake_read: assert property (reg_rd && reg_addr == SST_IDX_CORE_CONTROL
		|=> reg_rdata[2:1] == $past({core_vector, core_wake}))
		else $error("wake readback wrong");
	a_flag_read: assert property (reg_rd && reg_addr == SST_IDX_CORE_CONTROL
		&& core_wake |=> reg_rdata[0])
		else $error("wake without flag");
endmodule // sst_tx_props
bind sst_tx sst_tx_props i_sst_tx_props (.clk, .sys_rst, .reg_addr, .reg_rd,
	.reg_rdata, .shift_clock_pin_in, .shift_clock_pin_out, .shift_clock_pin_oe,
	.data_pin_out, .core_halt, .core_wake, .core_vector);

//--- dv/sst_master_model.sv
`timescale 1ns/1ns
// ----
// external shift clock master
// ----
module sst_master_model (
	output logic sclk, // shift clock to slave
	input wire logic data_in, // slave data pin
	input wire logic data_oe // slave data enable
);
	// clock stands low between frames
	initial sclk = 1'h0;
	// one clock per bit, taken at trailing edge, gap slows it
	task automatic run(input int n, input int gap, output logic [8:0] v);
		logic last;
		last = 1'h0;
		v = 9'h000;
		for (int i = 0; i < n; i++) begin
			sclk = 1'h1;
			#62;
			v[i] = data_oe ? data_in : ~last;
			last = v[i];
			sclk = 1'h0;
			#(63 + gap);
		end
	endtask
endmodule // sst_master_model

//--- dv/sst_tx_tb.sv
`timescale 1ns/1ns
module sst_tx_tb;
	import sst_pkg::*;
	typedef struct packed {logic [3:0] a; logic [7:0] w, e;} sst_row_type;
	logic clk, sys_rst, reg_wr, reg_rd, sclk_m, halt;
	logic ck_out, ck_oe, d_out, d_oe, wake, vec, irq;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [8:0] got;
	int bad_count = 0, check_count = 0, cyc = 0;
	sst_row_type rows [6] = '{'{4'h1, 8'h80, 8'h80}, '{4'h0, 8'h30, 8'h32},
		'{4'h3, 8'hd0, 8'hd0}, '{4'h5, 8'h01, 8'h01}, '{4'h7, 8'hff, 8'h00},
		'{4'h6, 8'hff, 8'h01}};
	// ----
	// clock and timeout
	// ----
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	sst_tx i_sst_tx (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .shift_clock_pin_in(ck_oe ? ck_out : sclk_m),
		.shift_clock_pin_out(ck_out), .shift_clock_pin_oe(ck_oe),
		.data_pin_out(d_out), .data_pin_oe(d_oe), .core_halt(halt),
		.core_wake(wake), .core_vector(vec), .irq);
	sst_master_model i_sst_master_model (.sclk(sclk_m), .data_in(d_out),
		.data_oe(d_oe));
	// ----
	// bus and report tasks
	// ----
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= {24'h000000, d};
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{sys_rst, reg_wr, reg_rd, halt} = 4'h8;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'h0;
		rd(4'h3, v);
		chk("int_ctl_reset", v, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, v);
			chk("reg_row", v, {24'h000000, rows[i].e});
		end
		chk("data_oe_on", {31'h0, d_oe}, 32'h1);
		$display("test table done");
		wr(4'h2, 8'ha5);
		i_sst_master_model.run(8, 0, got);
		chk("char_a5", {23'h0, got}, 32'ha5);
		chk("irq_up", {31'h0, irq}, 32'h1);
		rd(4'h4, v);
		chk("status", v, 32'h3);
		wr(4'h5, 8'h00);
		#1 chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(4'h4, 8'h03);
		wr(4'h5, 8'h01);
		#1 chk("irq_clear", {31'h0, irq}, 32'h0);
		$display("test irq done");
		wr(4'h2, 8'h3c);
		repeat (4) @(posedge clk);
		wr(4'h2, 8'hc3);
		halt <= 1'h1;
		repeat (4) @(posedge clk);
		rd(4'h6, v);
		chk("flag_wait", v, 32'h0);
		i_sst_master_model.run(8, 40, got);
		chk("char_3c", {23'h0, got}, 32'h3c);
		rd(4'h6, v);
		chk("wake_vec", v, 32'h7);
		chk("wake_pins", {30'h0, vec, wake}, 32'h3);
		wr(4'h3, 8'h50);
		rd(4'h6, v);
		chk("wake_only", v, 32'h3);
		i_sst_master_model.run(8, 0, got);
		chk("char_c3", {23'h0, got}, 32'hc3);
		@(posedge clk);
		halt <= 1'h0;
		$display("test halt done");
		wr(4'h0, 8'h71);
		wr(4'h2, 8'h0f);
		i_sst_master_model.run(9, 0, got);
		chk("char_nine", {23'h0, got}, 32'h10f);
		wr(4'h0, 8'hb0);
		#1 chk("data_oe_off", {31'h0, d_oe}, 32'h0);
		$display("test nine done");
		// reset again in mid-run: control back to idle defaults
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		rd(4'h0, v);
		chk("tx_ctl_reset", v, 32'h2);
		chk("oe_reset", {31'h0, d_oe}, 32'h0);
		$display("test reset again done");
		wrap_up();
	end
endmodule // sst_tx_tb
